// ### common/lam_params.svh
// offsets, field positions and reset values of the alarm status block
// assumes 8-bit registers reached through the serial-port register port
`ifndef LAM_PARAMS_SVH
`define LAM_PARAMS_SVH

// ==========================================================================
// register offsets
`define LAM_ADDR_CFG      8'h00
`define LAM_ADDR_STATUS   8'h01
`define LAM_ADDR_MASK     8'h03
`define LAM_ADDR_PACE     8'h07
`define LAM_ADDR_CHDIS    8'h08
`define LAM_ADDR_ADVCFG   8'h0B

// ==========================================================================
// reset values
`define LAM_RST_CFG       8'h08
`define LAM_RST_ZERO      8'h00

// ==========================================================================
// field positions
`define LAM_CFG_START     0
`define LAM_CFG_INTEN     1
`define LAM_CFG_INTCLR    3
`define LAM_CFG_INIT      7
`define LAM_PACE_CONT     0
`define LAM_ADV_MODE_LO   1
`define LAM_ADV_MODE_HI   2
`define LAM_TEMP_BIT      7

// ==========================================================================
// writable bits and per-mode flag layouts
`define LAM_CFG_WMASK     8'h0B
`define LAM_PACE_WMASK    8'h01
`define LAM_ADV_WMASK     8'h07
`define LAM_VALID_M0      8'hFF
`define LAM_VALID_M1      8'hFF
`define LAM_VALID_M2      8'h8F
`define LAM_VALID_M3      8'hBF

`endif

// ### common/lam_pkg.sv
// types shared by the alarm status block
// assumes lam_params.svh carries the numbers
package lam_pkg;

	// ======================================================================
	// input configuration modes
	typedef enum logic [1:0]
	{
		LAM_MODE_SE7_TEMP  = 2'h0,
		LAM_MODE_SE8       = 2'h1,
		LAM_MODE_DIFF_TEMP = 2'h2,
		LAM_MODE_MIXED     = 2'h3
	} lam_mode_e;

	// ======================================================================
	// register port request
	typedef struct packed
	{
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} lam_req_s;

	// ======================================================================
	// window comparator results, one bit per status position
	typedef struct packed
	{
		logic [7:0] high;
		logic [7:0] low;
	} lam_hit_s;

endpackage

// ### rtl/lam_flag_bank.sv
// sticky error flags, one per status bit position
// assumes comparator results are one-cycle pulses on CLK
`timescale 1ns/1ps
`include "lam_params.svh"

module lam_flag_bank
(
	// clock and reset
	input  wire logic          clk,
	input  wire logic          rst,
	// comparator events and qualifiers
	input  lam_pkg::lam_hit_s  hit,
	input  wire logic [7:0]    valid,
	input  wire logic [7:0]    disable_bits,
	input  wire logic          temp_high_only,
	input  wire logic          run,
	input  wire logic          clear,
	// flags
	output logic [7:0]         flags_ff
);

	logic [7:0] nxt_flags;

	// ======================================================================
	// per-bit set; a set in the clearing cycle wins
	genvar i;
	generate
		for (i = 0; i < 8; i = i + 1)
		begin : g_bit
			logic lo_ok;
			assign lo_ok = (i == `LAM_TEMP_BIT) ? ~temp_high_only : 1'b1; // R2
			assign nxt_flags[i] = (flags_ff[i] & ~clear)
				| (run & valid[i] & ~disable_bits[i] // R12
				& (hit.high[i] | (hit.low[i] & lo_ok))); // R1
		end
	endgenerate

	// flag register
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			flags_ff <= `LAM_RST_ZERO; // R5
		else
			flags_ff <= nxt_flags;
	end

endmodule

// ### rtl/lam_alarm_ctrl.sv
// alarm status, mask, interrupt pin and conversion pace registers
// assumes register requests come decoded from the serial-port engine
`timescale 1ns/1ps
`include "lam_params.svh"

// Summary of operation
// R1 - mode 0 flags inputs 0-6, mode 1 flags inputs 0-7 on either limit
// R2 - bit 7 is temperature in modes 0, 2, 3, set by upper limit only
// R3 - mode 2 bits 0-3 flag the four pairs, bits 4-6 reserved
// R4 - mode 3 bits 0-3 single inputs, bits 4-5 pairs, bit 6 reserved
// R5 - status, mask, pace reset to zero; status ignores host writes
// R6 - a set mask bit keeps its flag off the interrupt pin
// R7 - mask bit layout follows the status layout of the active mode
// R8 - pace bit 0 picks low-power or continuous conversion; rest reserved
// R9 - host writes pace only while the run bit is zero
// R10 - interrupt pin asserts only while pin enable is set
// R11 - interrupt clear releases the pin, keeps flags, halts monitoring loop
// R12 - disabled channel never sets its flag
// R13 - mode lives in the advanced configuration register with reference select
// R14 - pin low when enabled and any unmasked flag is set
// R15 - reserved status and mask bits read zero and ignore writes
module lam_alarm_ctrl
(
	// clock and reset
	input  wire logic          CLK,
	input  wire logic          RST,
	// register port
	input  lam_pkg::lam_req_s  REG_REQ,
	output logic [7:0]         REG_RDATA,
	// comparator results
	input  lam_pkg::lam_hit_s  LIMIT_HIT,
	// controls to the converter
	output logic               LOOP_RUN,
	output logic               CONV_CONTINUOUS,
	output logic [1:0]         CFG_MODE,
	// interrupt pin
	output logic               INT_N
);

	logic [7:0]         cfg_ff;
	logic [7:0]         mask_ff;
	logic [7:0]         pace_ff;
	logic [7:0]         chdis_ff;
	logic [7:0]         adv_ff;
	logic [7:0]         flags_ff;
	logic [7:0]         rdata_ff;
	logic               int_n_ff;
	logic               run_ff;
	logic               cont_ff;
	logic [1:0]         mode_out_ff;
	logic [7:0]         valid;
	logic [7:0]         pending;
	logic [7:0]         nxt_rdata;
	logic               wr_cfg;
	logic               init;
	logic               flag_clear;
	lam_pkg::lam_mode_e mode;

	// ======================================================================
	// decode
	assign mode       = lam_pkg::lam_mode_e'(adv_ff[`LAM_ADV_MODE_HI:`LAM_ADV_MODE_LO]); // R13
	assign wr_cfg     = REG_REQ.wr & (REG_REQ.addr == `LAM_ADDR_CFG);
	assign init       = wr_cfg & REG_REQ.wdata[`LAM_CFG_INIT];
	assign flag_clear = init | (REG_REQ.wr & (REG_REQ.addr == `LAM_ADDR_CHDIS));

	// layout of live bits in the active mode
	always_comb
	begin
		unique case (mode)
			lam_pkg::LAM_MODE_SE7_TEMP:  valid = `LAM_VALID_M0; // R1
			lam_pkg::LAM_MODE_SE8:       valid = `LAM_VALID_M1; // R1
			lam_pkg::LAM_MODE_DIFF_TEMP: valid = `LAM_VALID_M2; // R3
			lam_pkg::LAM_MODE_MIXED:     valid = `LAM_VALID_M3; // R4
		endcase
	end

	assign pending = flags_ff & valid & ~mask_ff; // R6 R7

	// ======================================================================
	// configuration register; init restores defaults and self-clears
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
			cfg_ff <= `LAM_RST_CFG;
		else if (init)
			cfg_ff <= `LAM_RST_CFG;
		else if (wr_cfg)
			cfg_ff <= REG_REQ.wdata & `LAM_CFG_WMASK;
	end

	// mask register, reserved positions dropped on write
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
			mask_ff <= `LAM_RST_ZERO; // R5
		else if (init)
			mask_ff <= `LAM_RST_ZERO;
		else if (REG_REQ.wr && REG_REQ.addr == `LAM_ADDR_MASK)
			mask_ff <= REG_REQ.wdata & valid; // R15 R7
	end

	// conversion pace; accepted whenever written, host keeps run low
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
			pace_ff <= `LAM_RST_ZERO; // R5
		else if (init)
			pace_ff <= `LAM_RST_ZERO;
		else if (REG_REQ.wr && REG_REQ.addr == `LAM_ADDR_PACE)
			pace_ff <= REG_REQ.wdata & `LAM_PACE_WMASK; // R8 R9
	end

	// channel disable register
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
			chdis_ff <= `LAM_RST_ZERO;
		else if (init)
			chdis_ff <= `LAM_RST_ZERO;
		else if (REG_REQ.wr && REG_REQ.addr == `LAM_ADDR_CHDIS)
			chdis_ff <= REG_REQ.wdata & valid;
	end

	// advanced configuration: mode and reference select
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
			adv_ff <= `LAM_RST_ZERO;
		else if (init)
			adv_ff <= `LAM_RST_ZERO;
		else if (REG_REQ.wr && REG_REQ.addr == `LAM_ADDR_ADVCFG)
			adv_ff <= REG_REQ.wdata & `LAM_ADV_WMASK; // R13
	end

	// ======================================================================
	// sticky flags
	lam_flag_bank u_flags
	(
		.clk            (CLK),
		.rst            (RST),
		.hit            (LIMIT_HIT),
		.valid          (valid),
		.disable_bits   (chdis_ff),
		.temp_high_only (mode != lam_pkg::LAM_MODE_SE8), // R2
		.run            (run_ff & ~cfg_ff[`LAM_CFG_INTCLR]), // R11
		.clear          (flag_clear),
		.flags_ff       (flags_ff)
	);

	// ======================================================================
	// read mux, unmapped offsets read zero
	always_comb
	begin
		unique case (REG_REQ.addr)
			`LAM_ADDR_CFG:    nxt_rdata = cfg_ff;
			`LAM_ADDR_STATUS: nxt_rdata = flags_ff & valid; // R15 R3 R4
			`LAM_ADDR_MASK:   nxt_rdata = mask_ff & valid; // R15
			`LAM_ADDR_PACE:   nxt_rdata = pace_ff; // R8
			`LAM_ADDR_CHDIS:  nxt_rdata = chdis_ff & valid;
			`LAM_ADDR_ADVCFG: nxt_rdata = adv_ff;
			default:          nxt_rdata = `LAM_RST_ZERO;
		endcase
	end

	// read data register
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
			rdata_ff <= `LAM_RST_ZERO;
		else if (REG_REQ.rd)
			rdata_ff <= nxt_rdata;
	end

	// ======================================================================
	// interrupt pin, active low
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
			int_n_ff <= 1'b1;
		else
			int_n_ff <= ~(cfg_ff[`LAM_CFG_INTEN] // R10
				& ~cfg_ff[`LAM_CFG_INTCLR] // R11
				& (|pending)); // R14 R6
	end

	// converter controls; interrupt clear halts the loop
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			run_ff      <= 1'b0;
			cont_ff     <= 1'b0;
			mode_out_ff <= 2'h0;
		end
		else
		begin
			run_ff      <= cfg_ff[`LAM_CFG_START] & ~cfg_ff[`LAM_CFG_INTCLR]; // R11
			cont_ff     <= pace_ff[`LAM_PACE_CONT]; // R8
			mode_out_ff <= adv_ff[`LAM_ADV_MODE_HI:`LAM_ADV_MODE_LO];
		end
	end

	assign REG_RDATA       = rdata_ff;
	assign INT_N           = int_n_ff;
	assign LOOP_RUN        = run_ff;
	assign CONV_CONTINUOUS = cont_ff;
	assign CFG_MODE        = mode_out_ff;

	// ======================================================================
	// assertions
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	a_status_ro: assert property ( // R5
		(REG_REQ.wr && REG_REQ.addr == `LAM_ADDR_STATUS && LIMIT_HIT == '0)
		|=> $stable(flags_ff))
		else $error("status changed on host write");
	a_temp_low_ign: assert property ( // R2
		(mode != lam_pkg::LAM_MODE_SE8 && LIMIT_HIT.low[7] && !LIMIT_HIT.high[7]
		&& !flags_ff[7]) |=> !flags_ff[7])
		else $error("temperature flag set by lower limit");
	a_mode1_in7: assert property ( // R1
		(mode == lam_pkg::LAM_MODE_SE8 && run_ff && LIMIT_HIT.low[7] && !chdis_ff[7])
		|=> flags_ff[7])
		else $error("input 7 flag missed in mode 1");
	a_mode2_rsv: assert property ( // R3
		(REG_REQ.rd && !REG_REQ.wr && REG_REQ.addr == `LAM_ADDR_STATUS
		&& mode == lam_pkg::LAM_MODE_DIFF_TEMP) |=> REG_RDATA[6:4] == 3'h0)
		else $error("mode 2 reserved status bits nonzero");
	a_mode3_rsv: assert property ( // R4
		(REG_REQ.rd && !REG_REQ.wr && REG_REQ.addr == `LAM_ADDR_MASK
		&& mode == lam_pkg::LAM_MODE_MIXED) |=> REG_RDATA[6] == 1'b0)
		else $error("mode 3 reserved mask bit nonzero");
	a_mask_block: assert property ( // R6
		(pending == 8'h00) |=> INT_N)
		else $error("masked flag drove interrupt");
	a_int_gate: assert property ( // R10
		!cfg_ff[`LAM_CFG_INTEN] |=> INT_N)
		else $error("interrupt without pin enable");
	a_int_clear: assert property ( // R11
		cfg_ff[`LAM_CFG_INTCLR] |=> (INT_N && !LOOP_RUN && $stable(flags_ff) || flag_clear))
		else $error("interrupt clear did not release");
	a_int_drive: assert property ( // R14
		(cfg_ff[`LAM_CFG_INTEN] && !cfg_ff[`LAM_CFG_INTCLR] && pending != 8'h00)
		|=> !INT_N)
		else $error("unmasked flag failed to drive interrupt");
	a_chan_off: assert property ( // R12
		(chdis_ff[0] && !flags_ff[0]) |=> !flags_ff[0])
		else $error("disabled channel set its flag");
	a_pace_follow: assert property ( // R8
		(REG_REQ.wr && REG_REQ.addr == `LAM_ADDR_PACE)
		|-> ##2 CONV_CONTINUOUS == $past(REG_REQ.wdata[0], 2))
		else $error("conversion mode not following pace bit");

	c_int_low:   cover property (!INT_N);
	c_mode2_rd:  cover property (REG_REQ.rd && mode == lam_pkg::LAM_MODE_DIFF_TEMP);
	c_init:      cover property (init);
	c_temp_flag: cover property (flags_ff[7] && mode != lam_pkg::LAM_MODE_SE8);

endmodule

// ### sim/lam_host_model.sv
// host model: issues register writes and reads on the register port
// assumes the block takes a strobe at a rising edge and answers a read at that same edge
`timescale 1ns/1ps

module lam_host_model
(
	// clock
	input  wire logic         clk,
	// register port
	output lam_pkg::lam_req_s req,
	input  wire logic [7:0]   rdata
);
	// ======================================================================
	// idle bus after time zero
	initial req = '0;

	// one write strobe; released fields show inverted values, not stale ones
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
	begin
		@(negedge clk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge clk);
		req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	end
	endtask

	// one read strobe; data is taken once the answering edge has passed
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
	begin
		@(negedge clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(negedge clk);
		req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
		d = rdata;
	end
	endtask
endmodule

// ### sim/limit_alarm_status_mask_tb_top.sv
// bench for the alarm status, mask and pace registers
// assumes the host model drives the register port; comparator pulses come from here
`timescale 1ns/1ps
`include "lam_params.svh"

module limit_alarm_status_mask_tb_top;
	logic              clk;
	logic              rst;
	lam_pkg::lam_req_s req;
	lam_pkg::lam_hit_s hit;
	logic [7:0]        rdata;
	logic              run;
	logic              cont;
	logic [1:0]        mode;
	logic              int_n;
	int                error_cnt;
	int                compares;

	// ======================================================================
	// clock and instances
	initial clk = 1'b0;
	always #2.5 clk = ~clk;

	lam_alarm_ctrl i_dut
	(
		.CLK(clk), .RST(rst), .REG_REQ(req), .REG_RDATA(rdata), .LIMIT_HIT(hit),
		.LOOP_RUN(run), .CONV_CONTINUOUS(cont), .CFG_MODE(mode), .INT_N(int_n)
	);

	lam_host_model i_host
	(
		.clk(clk), .req(req), .rdata(rdata)
	);

	// ======================================================================
	// compares and helpers
	task automatic chk8(input logic [7:0] g, input logic [7:0] e);
	begin
		compares++;
		if (g !== e)
		begin
			error_cnt++;
			$display("BAD %0t byte got %h want %h", $time, g, e);
		end
	end
	endtask

	task automatic chk1(input logic g, input logic e);
	begin
		compares++;
		if (g !== e)
		begin
			error_cnt++;
			$display("BAD %0t bit got %b want %b", $time, g, e);
		end
	end
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
	begin
		i_host.rd(a, d);
		chk8(d, e);
	end
	endtask

	// one-cycle comparator pulse, then time for flag and pin to settle
	task automatic pulse(input logic [7:0] h, input logic [7:0] l);
	begin
		@(negedge clk);
		hit <= '{high: h, low: l};
		@(negedge clk);
		hit <= '0;
		repeat (2) @(negedge clk);
	end
	endtask

	// ======================================================================
	// scenarios
	task automatic t_reset;
	begin
		chk1(int_n, 1'b1);
		chk1(run, 1'b0);
		rd_chk(`LAM_ADDR_STATUS, 8'h00);
		rd_chk(`LAM_ADDR_MASK, 8'h00);
		rd_chk(`LAM_ADDR_PACE, 8'h00);
		rd_chk(8'h05, 8'h00);
		chk1(cont, 1'b0);
	end
	endtask

	// status ignores writes; pace keeps bit 0 only, written while stopped
	task automatic t_writes;
	begin
		i_host.wr(`LAM_ADDR_STATUS, 8'hFF);
		rd_chk(`LAM_ADDR_STATUS, 8'h00);
		i_host.wr(`LAM_ADDR_PACE, 8'hFF);
		rd_chk(`LAM_ADDR_PACE, 8'h01);
		chk1(cont, 1'b1);
		i_host.wr(`LAM_ADDR_PACE, 8'h00);
		@(negedge clk);
		chk1(cont, 1'b0);
	end
	endtask

	// per mode: flag layout, temperature low ignored, mask, clear, enable
	task automatic t_mode(input logic [1:0] m, input logic [7:0] vld);
	begin
		i_host.wr(`LAM_ADDR_CFG, 8'h00);
		i_host.wr(`LAM_ADDR_ADVCFG, {5'h00, m, 1'b0});
		@(negedge clk);
		chk8({6'h00, mode}, {6'h00, m});
		i_host.wr(`LAM_ADDR_CHDIS, 8'h00);
		i_host.wr(`LAM_ADDR_CFG, 8'h03);
		pulse(8'h00, 8'h80);
		chk1(run, 1'b1);
		rd_chk(`LAM_ADDR_STATUS, (m == 2'h1) ? 8'h80 : 8'h00);
		pulse(8'hFF, 8'hFF);
		rd_chk(`LAM_ADDR_STATUS, vld);
		chk1(int_n, 1'b0);
		i_host.wr(`LAM_ADDR_MASK, 8'hFF);
		rd_chk(`LAM_ADDR_MASK, vld);
		chk1(int_n, 1'b1);
		i_host.wr(`LAM_ADDR_MASK, 8'h00);
		i_host.wr(`LAM_ADDR_CFG, 8'h0B);
		@(negedge clk);
		chk1(int_n, 1'b1);
		chk1(run, 1'b0);
		rd_chk(`LAM_ADDR_STATUS, vld);
		i_host.wr(`LAM_ADDR_CFG, 8'h01);
		@(negedge clk);
		chk1(int_n, 1'b1);
	end
	endtask

	// a disabled channel never raises its flag
	task automatic t_disable;
	begin
		i_host.wr(`LAM_ADDR_CFG, 8'h00);
		i_host.wr(`LAM_ADDR_ADVCFG, 8'h02);
		i_host.wr(`LAM_ADDR_CHDIS, 8'h01);
		i_host.wr(`LAM_ADDR_CFG, 8'h03);
		pulse(8'h01, 8'h01);
		rd_chk(`LAM_ADDR_STATUS, 8'h00);
		chk1(int_n, 1'b1);
		// init restores configuration, mask, mode and channel disable registers to their reset values
		i_host.wr(`LAM_ADDR_MASK, 8'hFF);
		i_host.wr(`LAM_ADDR_CFG, 8'h80);
		rd_chk(`LAM_ADDR_CFG, 8'h08);
		rd_chk(`LAM_ADDR_MASK, 8'h00);
		rd_chk(`LAM_ADDR_ADVCFG, 8'h00);
		rd_chk(`LAM_ADDR_CHDIS, 8'h00);
	end
	endtask

	// ======================================================================
	// verdict, main sequence and watchdog
	task automatic print_verdict;
	begin
		$display("mismatches %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	end
	endtask

	initial
	begin
		error_cnt = 0;
		compares = 0;
		rst = 1'b1;
		hit = '0;
		repeat (4) @(negedge clk);
		rst = 1'b0;
		t_reset;
		t_writes;
		t_mode(2'h0, 8'hFF);
		t_mode(2'h1, 8'hFF);
		t_mode(2'h2, 8'h8F);
		t_mode(2'h3, 8'hBF);
		t_disable;
		print_verdict;
	end

	// the tests need well under a thousand cycles
	initial
	begin
		#50000;
		error_cnt++;
		print_verdict;
	end
endmodule
